//--- dcff_params.svh
/*
  Constants for the dual-clock FIFO flag block: register offsets,
  status bit positions, reset values and offset load sequence codes.
  Assumes it is included by bare name from the package and the top.
*/
`ifndef DCFF_PARAMS_SVH
`define DCFF_PARAMS_SVH

// ==========================================================
// Sizes
`define DCFF_DATA_W 9
`define DCFF_DEPTH 64
`define DCFF_ADDR_W 6

// ==========================================================
// Register map, byte addresses
`define DCFF_REG_EMPTY_OFS 8'h00
`define DCFF_REG_FULL_OFS 8'h04
`define DCFF_REG_STATUS 8'h08
`define DCFF_REG_COUNT 8'h0C

// ==========================================================
// Status register bits
`define DCFF_ST_EMPTY_N 0
`define DCFF_ST_AE_N 1
`define DCFF_ST_AF_N 2
`define DCFF_ST_FULL_N 3
`define DCFF_ST_WE2_MODE 4

// ==========================================================
// Reset values
`define DCFF_OFS_DEFAULT 16'h0007

// ==========================================================
// Offset load and read sequence steps
`define DCFF_SEQ_EMPTY_LO 2'h0
`define DCFF_SEQ_EMPTY_HI 2'h1
`define DCFF_SEQ_FULL_LO 2'h2
`define DCFF_SEQ_FULL_HI 2'h3

`endif

//--- dcff_pkg.sv
/*
  Types shared by the flag block: pin bundle and flag bundle.
  Assumes dcff_params.svh sits in the same folder.
*/
package dcff_pkg;
  `include "dcff_params.svh"

  // ==========================================================
  // Pins of the write and read ports, all from outside clk_sys_in
  typedef struct packed {
    logic write_clock;
    logic read_clock;
    logic write_enable_primary_n;
    logic write_enable_two_or_load;
    logic read_enable_primary_n;
    logic read_enable_secondary_n;
    logic output_enable_n;
    logic [`DCFF_DATA_W-1:0] data;
  } dcff_pins_t;

  // ==========================================================
  // Status flags, all active low
  typedef struct packed {
    logic empty_indicator_n;
    logic almost_empty_indicator_n;
    logic almost_full_indicator_n;
    logic full_indicator_n;
  } dcff_flags_t;
endpackage : dcff_pkg

//--- dcff_ram.sv
/*
  Storage array of the FIFO: one synchronous write port and one
  combinational read port. Assumes the caller never overwrites a
  word that has not been read.
*/
`timescale 1ns/1ps
module dcff_ram #(
  parameter int DW = 9,
  parameter int AW = 6
) (
  input wire logic clk_sys_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);
  // ==========================================================
  // Array
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Read is combinational so the head word is ready at a read edge
  assign rd_data_out = mem[rd_addr_in];
endmodule : dcff_ram

//--- dcff_top.sv
/*
  Flag and configuration logic of a FIFO whose writer and reader
  clock it through pins. Both pin clocks are sampled on clk_sys_in,
  which must run well above twice either pin clock. Registers are
  reached over a classic Wishbone slave.
*/
`timescale 1ns/1ps
`include "dcff_params.svh"
module dcff_top
  import dcff_pkg::*;
#(
  parameter int DW = `DCFF_DATA_W,
  parameter int DEPTH = `DCFF_DEPTH,
  parameter int AW = `DCFF_ADDR_W
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire dcff_pins_t pins_in,
  output logic [DW-1:0] q_out,
  output logic q_oe_n_out,
  output dcff_flags_t flags_out,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);
  // ==========================================================
  // State
  typedef struct packed {
    dcff_pins_t sync1;
    dcff_pins_t sync2;
    logic wclk_prev;
    logic rclk_prev;
    logic we2_mode;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    dcff_flags_t flags;
    logic [DW-1:0] q;
    logic q_oe_n;
    logic [15:0] ofs_empty;
    logic [15:0] ofs_full;
    logic [1:0] ld_wseq;
    logic [1:0] ld_rseq;
    logic ack;
    logic [31:0] rdat;
  } dcff_state_t;

  localparam logic [16:0] DEPTH17 = 17'(DEPTH);

  dcff_state_t st_r;
  dcff_state_t st_nxt;

  // ==========================================================
  // Pin view and events
  dcff_pins_t pin;
  logic wr_edge;
  logic rd_edge;
  logic fifo_wr;
  logic fifo_rd;
  logic ofs_wr;
  logic ofs_rd;
  logic [15:0] eff_empty;
  logic [15:0] eff_full;
  logic [AW:0] wptr_nxt;
  logic [AW:0] rptr_nxt;
  logic [AW:0] cnt_w;
  logic [AW:0] cur_w;
  logic [16:0] cnt17;
  logic [16:0] cur_cnt17;
  logic [DW-1:0] ram_rd;
  logic wb_req;
  logic [31:0] read_word;

  // Second stage only; the first stage feeds nothing else
  assign pin = st_r.sync2;
  assign wr_edge = pin.write_clock & ~st_r.wclk_prev;
  assign rd_edge = pin.read_clock & ~st_r.rclk_prev;

  // Defaults forced while the pin is a write enable
  assign eff_empty = st_r.we2_mode ? `DCFF_OFS_DEFAULT : st_r.ofs_empty;
  assign eff_full = st_r.we2_mode ? `DCFF_OFS_DEFAULT : st_r.ofs_full;

  // Pin high is a write enable in both modes; either enable off blocks
  assign fifo_wr = wr_edge & ~pin.write_enable_primary_n
    & pin.write_enable_two_or_load & st_r.flags.full_indicator_n;
  assign ofs_wr = wr_edge & ~st_r.we2_mode
    & ~pin.write_enable_primary_n & ~pin.write_enable_two_or_load;
  assign fifo_rd = rd_edge & ~pin.read_enable_primary_n
    & ~pin.read_enable_secondary_n
    & (st_r.we2_mode | pin.write_enable_two_or_load)
    & st_r.flags.empty_indicator_n;
  assign ofs_rd = rd_edge & ~st_r.we2_mode
    & ~pin.read_enable_primary_n & ~pin.read_enable_secondary_n
    & ~pin.write_enable_two_or_load;

  assign wptr_nxt = st_r.wptr + {{AW{1'b0}}, fifo_wr};
  assign rptr_nxt = st_r.rptr + {{AW{1'b0}}, fifo_rd};
  // Difference kept at pointer width so a pointer wrap still reads right
  assign cnt_w = wptr_nxt - rptr_nxt;
  assign cur_w = st_r.wptr - st_r.rptr;
  assign cnt17 = 17'(cnt_w);
  assign cur_cnt17 = 17'(cur_w);

  // ==========================================================
  // Storage
  dcff_ram #(
    .DW(DW),
    .AW(AW)
  ) u_ram (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(fifo_wr),
    .wr_addr_in(st_r.wptr[AW-1:0]),
    .wr_data_in(pin.data[DW-1:0]),
    .rd_addr_in(st_r.rptr[AW-1:0]),
    .rd_data_out(ram_rd)
  );

  // ==========================================================
  // Register read mux
  assign wb_req = wb_cyc_in & wb_stb_in;

  always_comb begin
    read_word = 32'h0000_0000;
    case (wb_adr_in)
      `DCFF_REG_EMPTY_OFS: begin
        read_word = {16'h0000, eff_empty};
      end
      `DCFF_REG_FULL_OFS: begin
        read_word = {16'h0000, eff_full};
      end
      `DCFF_REG_STATUS: begin
        read_word[`DCFF_ST_EMPTY_N] = st_r.flags.empty_indicator_n;
        read_word[`DCFF_ST_AE_N] = st_r.flags.almost_empty_indicator_n;
        read_word[`DCFF_ST_AF_N] = st_r.flags.almost_full_indicator_n;
        read_word[`DCFF_ST_FULL_N] = st_r.flags.full_indicator_n;
        read_word[`DCFF_ST_WE2_MODE] = st_r.we2_mode;
      end
      `DCFF_REG_COUNT: begin
        read_word = {15'h0000, cur_cnt17};
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Pin sampling keeps running in reset so pin clocks may free-run
    st_nxt.sync1 = pins_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.wclk_prev = st_r.sync2.write_clock;
    st_nxt.rclk_prev = st_r.sync2.read_clock;
    st_nxt.q_oe_n = pin.output_enable_n;

    // Pointers move on their own pin edges
    st_nxt.wptr = wptr_nxt;
    st_nxt.rptr = rptr_nxt;

    // Write-side flags only move on a write edge, so a read just
    // before it shows at the next write edge and no sooner
    if (wr_edge) begin
      st_nxt.flags.full_indicator_n = (cnt17 != DEPTH17);
      st_nxt.flags.almost_full_indicator_n =
        ((cnt17 + {1'b0, eff_full}) < DEPTH17);
    end

    // Read-side flags only move on a read edge, so a first word
    // shows at the next read edge after it was written
    if (rd_edge) begin
      st_nxt.flags.empty_indicator_n = (cnt17 != 17'h0_0000);
      st_nxt.flags.almost_empty_indicator_n =
        (cnt17 > {1'b0, eff_empty});
    end

    if (fifo_rd) begin
      st_nxt.q = ram_rd;
    end

    // Offset load through the data pins, four steps in turn
    if (ofs_wr) begin
      case (st_r.ld_wseq)
        `DCFF_SEQ_EMPTY_LO: st_nxt.ofs_empty[7:0] = pin.data[7:0];
        `DCFF_SEQ_EMPTY_HI: st_nxt.ofs_empty[15:8] = pin.data[7:0];
        `DCFF_SEQ_FULL_LO: st_nxt.ofs_full[7:0] = pin.data[7:0];
        `DCFF_SEQ_FULL_HI: st_nxt.ofs_full[15:8] = pin.data[7:0];
        default: st_nxt.ofs_full = st_r.ofs_full;
      endcase
      st_nxt.ld_wseq = st_r.ld_wseq + 2'h1;
    end

    // Offset read back through the data outputs
    if (ofs_rd) begin
      case (st_r.ld_rseq)
        `DCFF_SEQ_EMPTY_LO: st_nxt.q = DW'(st_r.ofs_empty[7:0]);
        `DCFF_SEQ_EMPTY_HI: st_nxt.q = DW'(st_r.ofs_empty[15:8]);
        `DCFF_SEQ_FULL_LO: st_nxt.q = DW'(st_r.ofs_full[7:0]);
        `DCFF_SEQ_FULL_HI: st_nxt.q = DW'(st_r.ofs_full[15:8]);
        default: st_nxt.q = st_r.q;
      endcase
      st_nxt.ld_rseq = st_r.ld_rseq + 2'h1;
    end

    // Wishbone: ack one cycle after the request, write at the ack edge
    st_nxt.ack = wb_req & ~st_r.ack;
    if (wb_req & ~st_r.ack) begin
      st_nxt.rdat = read_word;
    end
    // Bus write wins over a pin load in the same cycle
    if (wb_req & st_r.ack & wb_we_in & ~st_r.we2_mode) begin
      if (wb_adr_in == `DCFF_REG_EMPTY_OFS) begin
        if (wb_sel_in[0]) begin
          st_nxt.ofs_empty[7:0] = wb_dat_in[7:0];
        end
        if (wb_sel_in[1]) begin
          st_nxt.ofs_empty[15:8] = wb_dat_in[15:8];
        end
      end
      if (wb_adr_in == `DCFF_REG_FULL_OFS) begin
        if (wb_sel_in[0]) begin
          st_nxt.ofs_full[7:0] = wb_dat_in[7:0];
        end
        if (wb_sel_in[1]) begin
          st_nxt.ofs_full[15:8] = wb_dat_in[15:8];
        end
      end
    end

    // ==========================================================
    // Reset: strap caught from the synchronised pin
    if (srst_in) begin
      st_nxt.we2_mode = st_r.sync2.write_enable_two_or_load;
      st_nxt.wptr = '0;
      st_nxt.rptr = '0;
      st_nxt.flags.empty_indicator_n = 1'b0;
      st_nxt.flags.almost_empty_indicator_n = 1'b0;
      st_nxt.flags.almost_full_indicator_n = 1'b1;
      st_nxt.flags.full_indicator_n = 1'b1;
      st_nxt.q = '0;
      st_nxt.q_oe_n = 1'b1;
      st_nxt.ofs_empty = `DCFF_OFS_DEFAULT;
      st_nxt.ofs_full = `DCFF_OFS_DEFAULT;
      st_nxt.ld_wseq = `DCFF_SEQ_EMPTY_LO;
      st_nxt.ld_rseq = `DCFF_SEQ_EMPTY_LO;
      st_nxt.ack = 1'b0;
      st_nxt.rdat = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st_r <= st_nxt;
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign q_out = st_r.q;
  assign q_oe_n_out = st_r.q_oe_n;
  assign flags_out = st_r.flags;
  assign wb_dat_out = st_r.rdat;
  assign wb_ack_out = st_r.ack;
endmodule : dcff_top

//--- dcff_top_props.sv
/* Checker for dcff_top ports.
   Assumes pin clock pulses held high for 6 clk. */
`timescale 1ns/1ps
module dcff_top_props
  import dcff_pkg::*;
#(
  parameter int DW = 9
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire dcff_pins_t pins_in,
  input wire logic [DW-1:0] q_out,
  input wire logic q_oe_n_out,
  input wire dcff_flags_t flags_out,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out
);
  // ==========================================================
  // Properties
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  property p_rst;
    disable iff (1'b0)
    srst_in |=> flags_out == 4'h3 && q_out == '0 && q_oe_n_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_full_af;
    !flags_out.full_indicator_n |-> !flags_out.almost_full_indicator_n;
  endproperty
  a_full_af: assert property (p_full_af) else $error("full");
  property p_empty_ae;
    !flags_out.empty_indicator_n |-> !flags_out.almost_empty_indicator_n;
  endproperty
  a_empty_ae: assert property (p_empty_ae) else $error("empty");
  // Write flags move only on a write clock edge
  property p_wflag;
    $changed({flags_out.almost_full_indicator_n,
      flags_out.full_indicator_n}) |-> pins_in.write_clock;
  endproperty
  a_wflag: assert property (p_wflag) else $error("wr flag");
  property p_rflag;
    $changed({flags_out.empty_indicator_n,
      flags_out.almost_empty_indicator_n}) |-> pins_in.read_clock;
  endproperty
  a_rflag: assert property (p_rflag) else $error("rd flag");
  property p_qchg;
    $changed(q_out) |-> pins_in.read_clock;
  endproperty
  a_qchg: assert property (p_qchg) else $error("q moved");
  property p_oe;
    !$past(srst_in) && !$past(srst_in, 2) && !$past(srst_in, 3)
      && !$past(srst_in, 4)
      |-> q_oe_n_out == $past(pins_in.output_enable_n, 3);
  endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_ack;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack");
  c_full: cover property (!flags_out.full_indicator_n);
  c_ae: cover property ($rose(flags_out.almost_empty_indicator_n));
  c_ack: cover property (wb_ack_out);
endmodule : dcff_top_props

bind dcff_top dcff_top_props #(.DW(DW)) u_dcff_top_props (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .pins_in(pins_in),
  .q_out(q_out), .q_oe_n_out(q_oe_n_out), .flags_out(flags_out),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out));

//--- dcff_pin_model.sv
/* Writer and reader pin model.
   Assumes clk_sys_in far above the pin clocks. */
`timescale 1ns/1ps
module dcff_pin_model
  import dcff_pkg::*;
(
  input wire logic clk_sys_in,
  input wire dcff_flags_t flags_in,
  output dcff_pins_t pins_out,
  output dcff_flags_t comp_out
);
  // ==========================================================
  // Width expansion flags, one device in this arrangement
  always_comb begin
    comp_out.empty_indicator_n = &{flags_in.empty_indicator_n};
    comp_out.full_indicator_n = &{flags_in.full_indicator_n};
    // Almost flags may come from any single device
    comp_out.almost_empty_indicator_n =
      flags_in.almost_empty_indicator_n;
    comp_out.almost_full_indicator_n =
      flags_in.almost_full_indicator_n;
  end
  // ==========================================================
  // Pin drive
  initial begin
    pins_out = '0;
    pins_out.write_enable_primary_n = 1'b1;
    pins_out.read_enable_primary_n = 1'b1;
    pins_out.read_enable_secondary_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick
  task automatic ctl(input logic two, input logic oen);
    pins_out.write_enable_two_or_load <= two;
    pins_out.output_enable_n <= oen;
  endtask : ctl
  // Long phases: the device sees pins through a 2 clk sync chain
  task automatic push(input logic [8:0] d, input logic e1n, input logic two);
    pins_out.data <= d;
    pins_out.write_enable_primary_n <= e1n;
    pins_out.write_enable_two_or_load <= two;
    tick(4);
    pins_out.write_clock <= 1'b1;
    tick(6);
    pins_out.write_clock <= 1'b0;
    pins_out.data <= ~d;
    tick(4);
  endtask : push
  task automatic pop(input logic en);
    pins_out.read_enable_primary_n <= !en;
    pins_out.read_enable_secondary_n <= !en;
    tick(4);
    pins_out.read_clock <= 1'b1;
    tick(6);
    pins_out.read_clock <= 1'b0;
    tick(4);
  endtask : pop
endmodule : dcff_pin_model

//--- dcff_top_bench.sv
/* Bench for dcff_top: pins via dcff_pin_model, registers via
   Wishbone. Assumes the checker binds itself. */
`timescale 1ns/1ps
module dcff_top_bench
  import dcff_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  dcff_pins_t pins;
  dcff_flags_t flags_out;
  dcff_flags_t comp;
  logic [31:0] wr_word = 32'h0000_0003;
  logic [8:0] q_out;
  logic q_oe_n_out;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [31:0] wb_dat_in = 32'h0;
  logic [31:0] wb_dat_out;
  logic [31:0] rd;
  logic wb_ack_out;
  int num_errors = 0;
  int samples_checked = 0;
  int c;
  `define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    num_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
  initial forever #25 clk_sys_in = ~clk_sys_in;
  dcff_pin_model u_dcff_pin_model (.clk_sys_in(clk_sys_in),
    .flags_in(flags_out), .pins_out(pins), .comp_out(comp));
  dcff_top u_dcff_top (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .pins_in(pins), .q_out(q_out), .q_oe_n_out(q_oe_n_out),
    .flags_out(flags_out), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(4'hF),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out));
  // ==========================================================
  // Tasks
  // Called just after a rising edge; the watchdog ends a hung wait
  task automatic wb(input logic we, input logic [7:0] a);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= wr_word;
    do begin
      @(posedge clk_sys_in);
    end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wb
  task automatic do_reset(input logic two);
    u_dcff_pin_model.ctl(two, 1'b1);
    srst_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask : do_reset
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // ==========================================================
  // Tests
  initial begin
    do_reset(1'b1);
    `CHK("flags", 4'h3, flags_out)
    `CHK("q_oe_n", 1'b1, q_oe_n_out)
    wb(1'b1, 8'h00);
    wb(1'b0, 8'h00);
    `CHK("ofs_n", 32'h7, rd)
    wb(1'b0, 8'h04);
    `CHK("ofs_m", 32'h7, rd)
    wb(1'b0, 8'h08);
    `CHK("we2", 1'b1, rd[4])
    wb(1'b0, 8'h10);
    `CHK("unmapped", 32'h0, rd)
    $display("test defaults done");
    u_dcff_pin_model.push(9'h155, 1'b1, 1'b1);
    u_dcff_pin_model.push(9'h0AA, 1'b0, 1'b0);
    wb(1'b0, 8'h0C);
    `CHK("count", 32'h0, rd)
    for (int k = 1; k <= 65; k++) begin
      u_dcff_pin_model.push(9'(k), 1'b0, 1'b1);
      c = (k > 64) ? 64 : k;
      `CHK("af_n", c < 57, flags_out.almost_full_indicator_n)
      `CHK("full_n", c < 64, flags_out.full_indicator_n)
      `CHK("comp_full_n", c < 64, comp.full_indicator_n)
    end
    wb(1'b0, 8'h0C);
    `CHK("count", 32'h40, rd)
    $display("test fill done");
    u_dcff_pin_model.ctl(1'b1, 1'b0);
    u_dcff_pin_model.pop(1'b1);
    `CHK("empty_n", 1'b1, flags_out.empty_indicator_n)
    `CHK("q_out", 9'h000, q_out)
    `CHK("q_oe_n", 1'b0, q_oe_n_out)
    for (int k = 1; k <= 65; k++) begin
      u_dcff_pin_model.pop(1'b1);
      c = (k > 64) ? 0 : 64 - k;
      `CHK("q_out", 9'(k > 64 ? 64 : k), q_out)
      `CHK("ae_n", c > 7, flags_out.almost_empty_indicator_n)
      `CHK("comp_ae_n", c > 7, comp.almost_empty_indicator_n)
      `CHK("empty_n", c > 0, flags_out.empty_indicator_n)
      `CHK("comp_empty_n", c > 0, comp.empty_indicator_n)
    end
    $display("test drain done");
    do_reset(1'b0);
    wb(1'b0, 8'h08);
    `CHK("we2", 1'b0, rd[4])
    for (int k = 0; k < 4; k++) begin
      u_dcff_pin_model.push(9'(k == 0 ? 3 : k == 2 ? 5 : 0), 1'b0, 1'b0);
    end
    wb(1'b0, 8'h00);
    `CHK("ofs_n", 32'h3, rd)
    wb(1'b0, 8'h04);
    `CHK("ofs_m", 32'h5, rd)
    for (int k = 0; k < 4; k++) begin
      u_dcff_pin_model.push(9'(k), 1'b0, 1'b1);
    end
    u_dcff_pin_model.pop(1'b1);
    `CHK("ae_n", 1'b1, flags_out.almost_empty_indicator_n)
    u_dcff_pin_model.ctl(1'b0, 1'b0);
    u_dcff_pin_model.pop(1'b1);
    `CHK("ofs_rd", 9'h003, q_out)
    wr_word = 32'h0000_0009;
    wb(1'b1, 8'h04);
    wb(1'b0, 8'h04);
    `CHK("ofs_m_bus", 32'h9, rd)
    $display("test load done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    stop_test();
  end
endmodule : dcff_top_bench
